// [inc/vpic_pkg.sv]
package vpic_pkg;
  // ==========================================================
  // Register offsets (byte addresses, word registers)
  localparam logic [11:0] OFS_MODE_BASE   = 12'h000; // 32 mode words
  localparam logic [11:0] OFS_VECTOR_BASE = 12'h080; // 32 vector words
  localparam logic [11:0] OFS_READOUT     = 12'h100;
  localparam logic [11:0] OFS_FAST_READ   = 12'h104;
  localparam logic [11:0] OFS_CURRENT     = 12'h108;
  localparam logic [11:0] OFS_PENDING     = 12'h10c;
  localparam logic [11:0] OFS_MASK        = 12'h110;
  localparam logic [11:0] OFS_CORE_STATE  = 12'h114;
  localparam logic [11:0] OFS_ENABLE_CMD  = 12'h120;
  localparam logic [11:0] OFS_DISABLE_CMD = 12'h124;
  localparam logic [11:0] OFS_CLEAR_CMD   = 12'h128;
  localparam logic [11:0] OFS_SET_CMD     = 12'h12c;
  localparam logic [11:0] OFS_END_SERVICE = 12'h130;
  localparam logic [11:0] OFS_SPURIOUS    = 12'h134;
  localparam logic [11:0] OFS_DEBUG       = 12'h138;
  localparam logic [11:0] OFS_FORCE_EN    = 12'h140;
  localparam logic [11:0] OFS_FORCE_DIS   = 12'h144;
  localparam logic [11:0] OFS_FORCE_STAT  = 12'h148;
  localparam logic [11:0] OFS_WPROT       = 12'h1e4;
  // ==========================================================
  // Field layout of a mode word
  localparam int PRIO_LSB = 0;   // priority_level_field [2:0]
  localparam int TRIG_LSB = 5;   // trigger_condition_field [6:5]
  localparam int DBG_PROTECT = 0;
  localparam int DBG_GMASK   = 1;
  localparam logic [23:0] WPROT_KEY = 24'h5a5a5a; // arbitrary key
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int NUM_SRC   = 32;
  localparam int STACK_DEP = 8;
  // ==========================================================
  // Trigger conditions
  typedef enum logic [1:0] {
    VPIC_LEVEL_LOW  = 2'h0,
    VPIC_EDGE_FALL  = 2'h1,
    VPIC_LEVEL_HIGH = 2'h2,
    VPIC_EDGE_RISE  = 2'h3
  } vpic_trig_e;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vpic_bus_s;
  typedef struct packed {
    logic [4:0] src;
    logic [2:0] prio;
  } vpic_frame_s;
endpackage : vpic_pkg

// [hw/vpic_ctrl.sv]
`timescale 1ns/1ps
module vpic_ctrl #(
  parameter int EXT_MASK = 32'h0000_0001 // Set bits mark external sources
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire vpic_pkg::vpic_bus_s bus,
  output logic [31:0]             rdata,
  input  wire logic               fast_request_pin,
  input  wire logic [15:0]        system_source,
  input  wire logic [31:2]        peripheral_source_ids,
  output logic                    normal_request_out_n,
  output logic                    fast_request_out_n,
  output logic                    wake_out
);
  import vpic_pkg::*;

  if (NUM_SRC != 32 || STACK_DEP != 8) begin : gSizeCheck
    $error("vpic_ctrl: sizes fixed");
  end

  // ==========================================================
  // Reset release and input synchronisers (always-on clock)
  logic [1:0]  rstSync;
  logic        rstN;
  logic [31:0] syncA;
  logic [31:0] srcLine;
  logic [31:0] rawIn;
  logic [15:0] sysA;
  logic [15:0] sysB;

  // System lines are synchronised before the OR, so no raw pin feeds logic
  assign rawIn = {peripheral_source_ids, |sysB, fast_request_pin};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Two-stage synchroniser; only stage two is read
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      sysA    <= 16'h0;
      sysB    <= 16'h0;
      syncA   <= 32'h0;
      srcLine <= 32'h0;
    end else begin
      sysA    <= system_source;
      sysB    <= sysA;
      syncA   <= rawIn;
      srcLine <= syncA;
    end
  end

  // ==========================================================
  // Configuration storage
  logic [31:0] modeWord [NUM_SRC];
  logic [31:0] vecWord  [NUM_SRC];
  logic [31:0] enMask;
  logic [31:0] forceMask;
  logic [31:0] spurVec;
  logic        protectMode;
  logic        genMask;
  logic        wprotOn;
  logic [31:0] edgeHeld;
  logic [31:0] prevLine;
  logic        cfgWr;
  logic        readoutRd;
  logic        fastRd;
  logic        endWr;

  function automatic logic isAt(input logic [11:0] a, input logic [11:0] o);
    isAt = (a == o);
  endfunction : isAt

  assign cfgWr     = bus.wr && !wprotOn;
  assign readoutRd = bus.rd && isAt(bus.addr, OFS_READOUT) && !protectMode;
  assign fastRd    = bus.rd && isAt(bus.addr, OFS_FAST_READ) && !protectMode;
  assign endWr     = bus.wr && isAt(bus.addr, OFS_END_SERVICE);

  // Mode and vector words, write-protected
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        modeWord[i] <= RESET_WORD;
        vecWord[i]  <= RESET_WORD;
      end
      spurVec <= RESET_WORD;
    end else if (cfgWr) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (bus.addr == OFS_MODE_BASE + 12'(4 * i)) begin
          modeWord[i] <= bus.wdata;
        end
        if (bus.addr == OFS_VECTOR_BASE + 12'(4 * i)) begin
          vecWord[i] <= bus.wdata;
        end
      end
      if (isAt(bus.addr, OFS_SPURIOUS)) begin
        spurVec <= bus.wdata;
      end
    end
  end

  // Enable and fast-forcing masks, debug control
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      enMask      <= 32'h0;
      forceMask   <= 32'h0;
      protectMode <= 1'b0;
      genMask     <= 1'b0;
    end else if (cfgWr) begin
      if (isAt(bus.addr, OFS_ENABLE_CMD))  enMask <= enMask | bus.wdata;
      if (isAt(bus.addr, OFS_DISABLE_CMD)) enMask <= enMask & ~bus.wdata;
      if (isAt(bus.addr, OFS_FORCE_EN))    forceMask <= forceMask | {bus.wdata[31:1], 1'b0};
      if (isAt(bus.addr, OFS_FORCE_DIS))   forceMask <= forceMask & ~bus.wdata;
      if (isAt(bus.addr, OFS_DEBUG)) begin
        protectMode <= bus.wdata[DBG_PROTECT];
        genMask     <= bus.wdata[DBG_GMASK];
      end
    end
  end

  // Write protection, key checked, never itself protected
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wprotOn <= 1'b0;
    end else if (bus.wr && isAt(bus.addr, OFS_WPROT) && bus.wdata[31:8] == WPROT_KEY) begin
      wprotOn <= bus.wdata[0];
    end
  end

  // ==========================================================
  // Source input stage
  logic [31:0] condNow;
  logic [31:0] edgeMode;
  logic [31:0] edgeSeen;
  logic [31:0] pending;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      logic [1:0] t;
      t = modeWord[i][TRIG_LSB +: 2];
      edgeMode[i] = t[0];
      if (EXT_MASK[i]) begin
        case (vpic_trig_e'(t))
          VPIC_LEVEL_LOW:  condNow[i] = !srcLine[i];
          VPIC_LEVEL_HIGH: condNow[i] = srcLine[i];
          VPIC_EDGE_FALL:  condNow[i] = !srcLine[i] && prevLine[i];
          VPIC_EDGE_RISE:  condNow[i] = srcLine[i] && !prevLine[i];
          default:         condNow[i] = 1'b0;
        endcase
      end else begin
        condNow[i] = t[0] ? (srcLine[i] && !prevLine[i]) : srcLine[i];
      end
      edgeSeen[i] = edgeMode[i] && condNow[i];
      pending[i]  = edgeMode[i] ? edgeHeld[i] : condNow[i];
    end
  end

  // ==========================================================
  // Priority resolver
  logic [31:0] active;
  logic [4:0]  bestSrc;
  logic [2:0]  bestPrio;
  logic        bestAny;
  logic [4:0]  curSrc;
  logic [2:0]  curPrio;
  logic        inService;

  assign active = pending & enMask & ~forceMask;

  always_comb begin
    bestSrc  = 5'h0;
    bestPrio = 3'h0;
    bestAny  = 1'b0;
    for (int i = NUM_SRC - 1; i >= 1; i--) begin
      // Walk downward; >= lets lower number win a tie
      if (active[i] &&
          (!bestAny || modeWord[i][PRIO_LSB +: 3] >= bestPrio)) begin
        bestAny  = 1'b1;
        bestSrc  = 5'(i);
        bestPrio = modeWord[i][PRIO_LSB +: 3];
      end
    end
  end

  // ==========================================================
  // Nesting stack
  vpic_frame_s stack [STACK_DEP];
  logic [3:0]  depth;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      depth     <= 4'h0;
      curSrc    <= 5'h0;
      curPrio   <= 3'h0;
      inService <= 1'b0;
      for (int i = 0; i < STACK_DEP; i++) stack[i] <= '0;
    end else if (readoutRd && bestAny) begin
      if (inService && depth < 4'(STACK_DEP)) begin
        stack[depth[2:0]] <= '{src: curSrc, prio: curPrio};
        depth <= depth + 4'h1;
      end
      curSrc    <= bestSrc;
      curPrio   <= bestPrio;
      inService <= 1'b1;
    end else if (endWr && inService) begin
      if (depth != 4'h0) begin
        curSrc  <= stack[depth[2:0] - 3'h1].src;
        curPrio <= stack[depth[2:0] - 3'h1].prio;
        depth   <= depth - 4'h1;
      end else begin
        inService <= 1'b0;
        curSrc    <= 5'h0;
        curPrio   <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Edge memory: set wins over every clear
  logic [31:0] edgeClr;

  always_comb begin
    edgeClr = 32'h0;
    if (cfgWr && isAt(bus.addr, OFS_CLEAR_CMD)) edgeClr = bus.wdata;
    if (readoutRd && bestAny && !forceMask[bestSrc]) edgeClr[bestSrc] = 1'b1;
    if (fastRd) edgeClr[0] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      edgeHeld <= 32'h0;
      prevLine <= 32'h0;
    end else begin
      prevLine <= srcLine;
      edgeHeld <= ((edgeHeld & ~edgeClr) | edgeSeen
                  | ((cfgWr && isAt(bus.addr, OFS_SET_CMD)) ? bus.wdata : 32'h0)) & edgeMode;
    end
  end

  // ==========================================================
  // Request outputs, registered, active low; wake_out registered, active high
  logic wantNormal;
  logic wantFast;

  assign wantNormal = bestAny && (!inService || bestPrio > curPrio);
  assign wantFast   = |(pending & enMask & (forceMask | 32'h1));

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      normal_request_out_n <= 1'b1;
      fast_request_out_n   <= 1'b1;
      wake_out             <= 1'b0;
    end else begin
      normal_request_out_n <= !(wantNormal && !genMask);
      fast_request_out_n   <= !(wantFast && !genMask);
      wake_out             <= wantNormal || wantFast;
    end
  end

  // ==========================================================
  // Read data, one cycle after strobe
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdata <= 32'h0;
    end else if (bus.rd) begin
      rdata <= 32'h0;
      for (int i = 0; i < NUM_SRC; i++) begin
        if (bus.addr == OFS_MODE_BASE + 12'(4 * i))   rdata <= modeWord[i];
        if (bus.addr == OFS_VECTOR_BASE + 12'(4 * i)) rdata <= vecWord[i];
      end
      case (bus.addr)
        OFS_READOUT:    rdata <= bestAny ? vecWord[bestSrc] : spurVec;
        OFS_FAST_READ:  rdata <= vecWord[0];
        OFS_CURRENT:    rdata <= {27'h0, curSrc};
        OFS_PENDING:    rdata <= pending;
        OFS_MASK:       rdata <= enMask;
        OFS_CORE_STATE: rdata <= {30'h0, !normal_request_out_n, !fast_request_out_n};
        OFS_SPURIOUS:   rdata <= spurVec;
        OFS_DEBUG:      rdata <= {30'h0, genMask, protectMode};
        OFS_FORCE_STAT: rdata <= forceMask;
        OFS_WPROT:      rdata <= {31'h0, wprotOn};
        default:        ;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule : vpic_ctrl

// [sim/vpic_chk.sv]
`timescale 1ns/1ps
module vpic_chk (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire vpic_pkg::vpic_bus_s bus,
  input wire logic [31:0]         rdata,
  input wire logic                normal_request_out_n,
  input wire logic                fast_request_out_n,
  input wire logic                wake_out
);
  import vpic_pkg::*;
  logic gmask;
  logic wprot;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Write protection as last keyed
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) wprot <= 1'b0;
    else if (bus.wr && bus.addr == OFS_WPROT && bus.wdata[31:8] == WPROT_KEY) wprot <= bus.wdata[0];
  end
  // General mask as last written through an open port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) gmask <= 1'b0;
    else if (bus.wr && !wprot && bus.addr == OFS_DEBUG) gmask <= bus.wdata[DBG_GMASK];
  end
  // ==========================================================
  // Output relations
  property p_quiet;
    $rose(reset_n) |-> (normal_request_out_n && fast_request_out_n && !wake_out) [*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("request right after reset");
  property p_idle;
    !$past(bus.rd) |-> rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside its cycle");
  property p_wake;
    !normal_request_out_n || !fast_request_out_n |-> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("request without wake");
  property p_gmask;
    gmask && $past(gmask, 3) |-> normal_request_out_n && fast_request_out_n;
  endproperty
  a_gmask: assert property (p_gmask) else $error("request under general mask");
  property p_image;
    bus.rd && bus.addr == OFS_CORE_STATE |=> !$stable(normal_request_out_n)
      || !$stable(fast_request_out_n)
      || rdata[1:0] == ~{$past(normal_request_out_n), $past(fast_request_out_n)};
  endproperty
  a_image: assert property (p_image) else $error("core state image wrong");
  property p_vec;
    !wprot && bus.wr && bus.addr[11:7] == 5'h01 ##1 bus.rd && bus.addr == $past(bus.addr)
      |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector readback wrong");
  property p_prio;
    !wprot && bus.wr && bus.addr[11:7] == 5'h00 ##1 bus.rd && bus.addr == $past(bus.addr)
      |=> rdata[2:0] == 3'($past(bus.wdata, 2));
  endproperty
  a_prio: assert property (p_prio) else $error("priority readback wrong");
  property p_dbg;
    $past(bus.rd) && $past(bus.addr) == OFS_DEBUG |-> rdata[DBG_GMASK] == gmask;
  endproperty
  a_dbg: assert property (p_dbg) else $error("general mask readback wrong");
endmodule : vpic_chk
bind vpic_ctrl vpic_chk vpic_chk_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus),
  .rdata(rdata), .normal_request_out_n(normal_request_out_n),
  .fast_request_out_n(fast_request_out_n), .wake_out(wake_out));

// [sim/vpic_core_model.sv]
`timescale 1ns/1ps
module vpic_core_model (
  input  wire logic sysClk,
  input  wire logic resetN,
  input  wire logic wakeIn,
  input  wire logic sleepReq,
  output logic      awake
);
  // Core leaves idle on any wake event, sleeps on request
  always_ff @(posedge sysClk or negedge resetN) begin
    if (!resetN) awake <= 1'b0;
    else if (wakeIn) awake <= 1'b1;
    else if (sleepReq) awake <= 1'b0;
  end
endmodule : vpic_core_model

// [sim/vpic_ctrl_tb_top.sv]
`timescale 1ns/1ps
module vpic_ctrl_tb_top;
  import vpic_pkg::*;
  logic        sysClk;
  logic        resetN;
  vpic_bus_s   bus;
  logic [31:0] rdata;
  logic        fastPin;
  logic [15:0] sysSrc;
  logic [31:2] perSrc;
  logic        normalReqN;
  logic        fastReqN;
  logic        wake;
  logic        awake;
  logic        sleepReq;
  logic [31:0] got;
  int          numErrors;
  int          nCompared;
  int          cycles;
  wire  [2:0]  outs = {normalReqN, fastReqN, wake};
  // ==========================================================
  // Block and core model
  vpic_ctrl vpic_ctrl_i (.sys_clk(sysClk), .reset_n(resetN), .bus(bus), .rdata(rdata),
    .fast_request_pin(fastPin), .system_source(sysSrc), .peripheral_source_ids(perSrc),
    .normal_request_out_n(normalReqN), .fast_request_out_n(fastReqN), .wake_out(wake));
  vpic_core_model vpic_core_model_i (.sysClk(sysClk), .resetN(resetN), .wakeIn(wake),
    .sleepReq(sleepReq), .awake(awake));
  // Clock and hang guard
  initial begin
    sysClk = 1'b0;
    forever #20 sysClk = ~sysClk;
  end
  always @(posedge sysClk) begin
    cycles++;
    if (cycles > 5000) begin
      numErrors++;
      print_verdict();
    end
  end
  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bx(input logic [11:0] a, input logic [31:0] d, input logic w, input logic r);
    @(posedge sysClk);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask : bx
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bx(a, d, 1'b1, 1'b0);
    bx(12'h0, 32'h0, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    bx(a, 32'h0, 1'b0, 1'b1);
    bx(12'h0, 32'h0, 1'b0, 1'b0);
    #1 got = rdata;
  endtask : rd
  task automatic wrRd(input logic [11:0] a, input logic [31:0] d);
    bx(a, d, 1'b1, 1'b0);
    rd(a);
    chk(got, d);
  endtask : wrRd
  // Wait a bounded time for {normal, fast, wake}
  task automatic waitOut(input logic [2:0] e, input int n);
    #1;
    for (int i = 0; i < n && outs !== e; i++) begin
      @(posedge sysClk);
      #1;
    end
    chk({29'h0, outs}, {29'h0, e});
  endtask : waitOut
  task automatic print_verdict();
    if (numErrors == 0 && nCompared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // Equal levels, then a higher one arriving in service
  task automatic tLevels();
    wrRd(OFS_MODE_BASE + 12'h10, 32'h2);
    wr(OFS_MODE_BASE + 12'h18, 32'h2);
    wr(OFS_MODE_BASE + 12'h24, 32'h6);
    wrRd(OFS_VECTOR_BASE + 12'h10, 32'hc0de0004);
    wrRd(OFS_VECTOR_BASE + 12'h24, 32'hc0de0009);
    wr(OFS_ENABLE_CMD, 32'h250);
    perSrc[6] <= 1'b1;
    perSrc[4] <= 1'b1;
    waitOut(3'b011, 10);
    rd(OFS_CORE_STATE);
    rd(OFS_READOUT);
    chk(got, 32'hc0de0004);
    waitOut(3'b110, 10);
    perSrc[9] <= 1'b1;
    waitOut(3'b011, 10);
    rd(OFS_READOUT);
    chk(got, 32'hc0de0009);
    perSrc <= '0;
    wr(OFS_END_SERVICE, 32'h0);
    rd(OFS_CURRENT);
    chk(got, 32'h4);
    wr(OFS_END_SERVICE, 32'h0);
    waitOut(3'b110, 10);
  endtask : tLevels
  // Edge source, then the same source forced to fast
  task automatic tEdge();
    wr(OFS_MODE_BASE + 12'h1c, 32'h21);
    wr(OFS_VECTOR_BASE + 12'h1c, 32'hc0de0007);
    wr(OFS_ENABLE_CMD, 32'h80);
    for (int f = 0; f < 2; f++) begin
      perSrc[7] <= 1'b1;
      rd(OFS_PENDING);
      perSrc[7] <= 1'b0;
      waitOut(f ? 3'b101 : 3'b011, 10);
      rd(OFS_READOUT);
      chk(got, f ? RESET_WORD : 32'hc0de0007);
      repeat (8) @(posedge sysClk);
      waitOut(f ? 3'b101 : 3'b110, 1);
      wr(OFS_END_SERVICE, 32'h0);
      wr(OFS_FORCE_EN, 32'h80);
    end
    wr(OFS_CLEAR_CMD, 32'h80);
    waitOut(3'b110, 10);
  endtask : tEdge
  // Fast pin under all four trigger conditions
  task automatic tFast();
    wr(OFS_ENABLE_CMD, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_MODE_BASE, {25'h0, 2'(k), 5'h0});
      fastPin <= !k[1];
      repeat (6) @(posedge sysClk);
      wr(OFS_CLEAR_CMD, 32'h1);
      waitOut(3'b110, 10);
      fastPin <= k[1];
      waitOut(3'b101, 10);
      fastPin <= !k[1];
      if (k[0]) rd(OFS_FAST_READ);
      waitOut(3'b110, 10);
    end
  endtask : tFast
  // System source under the general mask, then unmasked
  task automatic tSys();
    wr(OFS_VECTOR_BASE + 12'h4, 32'hc0de0001);
    wr(OFS_MODE_BASE + 12'h4, 32'h3);
    wr(OFS_ENABLE_CMD, 32'h2);
    sleepReq <= 1'b1;
    wr(OFS_DEBUG, 32'h2);
    sleepReq <= 1'b0;
    rd(OFS_DEBUG);
    sysSrc <= 16'h0200;
    waitOut(3'b111, 10);
    repeat (2) @(posedge sysClk);
    #1 chk({31'h0, awake}, 32'h1);
    wr(OFS_DEBUG, 32'h0);
    waitOut(3'b011, 10);
    rd(OFS_READOUT);
    chk(got, 32'hc0de0001);
    sysSrc <= 16'h0;
    wr(OFS_END_SERVICE, 32'h0);
    waitOut(3'b110, 10);
  endtask : tSys
  // Protect mode, write protection and force status
  task automatic tProtect();
    wr(OFS_VECTOR_BASE + 12'h8, 32'hc0de0002);
    wr(OFS_MODE_BASE + 12'h8, 32'h25);
    wr(OFS_ENABLE_CMD, 32'h4);
    wr(OFS_SET_CMD, 32'h4);
    waitOut(3'b011, 10);
    wr(OFS_DEBUG, 32'h1);
    rd(OFS_READOUT);
    chk(got, 32'hc0de0002);
    rd(OFS_CURRENT);
    chk(got, 32'h0);
    waitOut(3'b011, 1);
    wr(OFS_DEBUG, 32'h0);
    rd(OFS_READOUT);
    chk(got, 32'hc0de0002);
    waitOut(3'b110, 10);
    wr(OFS_END_SERVICE, 32'h0);
    wr(OFS_WPROT, {WPROT_KEY, 8'h01});
    wr(OFS_DISABLE_CMD, 32'h4);
    rd(OFS_MASK);
    chk(got, 32'h2d7);
    wr(OFS_WPROT, {WPROT_KEY, 8'h00});
    wr(OFS_DISABLE_CMD, 32'h4);
    rd(OFS_MASK);
    chk(got, 32'h2d3);
    rd(OFS_FORCE_STAT);
    chk(got, 32'h80);
  endtask : tProtect
  // Main sequence
  initial begin
    bus = '0;
    fastPin = 1'b1;
    sysSrc = '0;
    perSrc = '0;
    sleepReq = 1'b0;
    resetN = 1'b0;
    repeat (8) @(posedge sysClk);
    resetN <= 1'b1;
    repeat (3) @(posedge sysClk);
    waitOut(3'b110, 1);
    tLevels();
    tEdge();
    tFast();
    tSys();
    tProtect();
    print_verdict();
  end
endmodule : vpic_ctrl_tb_top
